//--- hdl/ici_pkg.sv
package ici_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned PIN_W = 16;
  localparam logic [7:0] PTR_INPUT0 = 8'h00;
  localparam logic [7:0] PTR_INPUT1 = 8'h01;
  localparam logic [7:0] INREG_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic INT_DRIVE_LEVEL = 1'b0;
  localparam int unsigned SYNC_STAGES = 2;
endpackage

//--- hdl/ici_port.sv
module ici_port
  import ici_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [PORT_W-1:0] pin_level,
  input  wire logic [PORT_W-1:0] dir_cfg,
  input  wire logic              capture,
  output logic      [PORT_W-1:0] pin_sync,
  output logic      [PORT_W-1:0] in_reg,
  output logic                   mismatch
);
  logic [PORT_W-1:0] meta_reg;
  logic [PORT_W-1:0] sync_reg;
  logic [PORT_W-1:0] in_hold_reg;
  logic [PORT_W-1:0] in_next;
  logic [PORT_W-1:0] diff;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end else begin
      meta_reg <= pin_level; // RULE11
      sync_reg <= meta_reg;
    end
  end

  // captured regardless of direction; there is no write path
  assign in_next = capture ? sync_reg : in_hold_reg; // RULE8

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_hold_reg <= INREG_RST;
    end else begin
      in_hold_reg <= in_next; // RULE3
    end
  end

  // a level compare, not an edge: returning to the old level clears it
  assign diff = sync_reg ^ in_hold_reg; // RULE1 RULE2
  // only bits whose direction bit is one take part
  assign mismatch = |(diff & dir_cfg); // RULE4 RULE6 RULE7

  assign pin_sync = sync_reg;
  assign in_reg = in_hold_reg;
endmodule

//--- hdl/ici_top.sv
// How it works
// RULE1 - the interrupt goes active when an input pin differs from its captured input register bit.
// RULE2 - the interrupt goes away by itself once the pin returns to its captured level.
// RULE3 - reading a port's input register recaptures its pins and so clears that port's cause.
// RULE4 - pins whose direction bit selects output never take part in the interrupt condition.
// RULE5 - each 8-bit port keeps its own cause, and a read of one port leaves the other untouched.
// RULE6 - turning a pin from output to input raises the interrupt if its level differs from the register.
// RULE7 - a direction bit of one makes the pin an input, a zero makes it an output.
// RULE8 - the input registers capture pin levels whatever the direction and cannot be written.
// RULE9 - pointer value 0 selects port 0's input register and value 1 selects port 1's.
// RULE10 - the capture of a read happens on the strobe marking the acknowledge clock falling edge.
// RULE11 - pins are synchronised before the compare and the line is pulled low while any cause stands.
module ici_top
  import ici_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic [PIN_W-1:0] PIN_LEVEL,
  input  wire logic [PIN_W-1:0] DIR_CFG,
  input  wire logic [7:0]       READ_PTR,
  input  wire logic             READ_CAPTURE,
  output logic      [7:0]       INPUT_PORT0,
  output logic      [7:0]       INPUT_PORT1,
  output logic                  INT_O,
  output logic                  INT_OE
);
  logic             rst_meta_reg;
  logic             rst_sync_reg;
  logic             rstn;
  logic             primed_reg;
  logic [SYNC_STAGES-1:0] warm_reg;
  logic             int_oe_reg;
  logic             int_oe_next;
  logic             int_o_reg;
  logic             sel_port0;
  logic             sel_port1;
  logic             cap0;
  logic             cap1;
  logic             mism0;
  logic             mism1;
  logic [7:0]       sync0;
  logic [7:0]       sync1;
  logic [7:0]       reg0;
  logic [7:0]       reg1;
  logic [7:0]       dir0;
  logic [7:0]       dir1;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rstn = rst_sync_reg;

  // input register default follows the pins, so load on every edge after release until primed
  // pins need two edges to reach the synchroniser output, so priming waits three edges, one past that
  always_ff @(posedge CLK or negedge rstn) begin
    if (!rstn) begin
      warm_reg   <= '0;
      primed_reg <= 1'b0;
    end else begin
      warm_reg   <= {warm_reg[SYNC_STAGES-2:0], 1'b1};
      primed_reg <= warm_reg[SYNC_STAGES-1];
    end
  end

  assign dir0 = DIR_CFG[7:0];
  assign dir1 = DIR_CFG[15:8];
  assign sel_port0 = (READ_PTR == PTR_INPUT0); // RULE9
  assign sel_port1 = (READ_PTR == PTR_INPUT1); // RULE9
  // the strobe is one cycle wide; reads of other registers never recapture
  assign cap0 = !primed_reg || (READ_CAPTURE && sel_port0); // RULE10 RULE5
  assign cap1 = !primed_reg || (READ_CAPTURE && sel_port1); // RULE10 RULE5

  ici_port u_port0 (
    .clk       (CLK),
    .rstn      (rstn),
    .pin_level (PIN_LEVEL[7:0]),
    .dir_cfg   (dir0),
    .capture   (cap0),
    .pin_sync  (sync0),
    .in_reg    (reg0),
    .mismatch  (mism0)
  );

  ici_port u_port1 (
    .clk       (CLK),
    .rstn      (rstn),
    .pin_level (PIN_LEVEL[15:8]),
    .dir_cfg   (dir1),
    .capture   (cap1),
    .pin_sync  (sync1),
    .in_reg    (reg1),
    .mismatch  (mism1)
  );

  // gated by primed so the unknown power-up pins cannot fire a false interrupt
  assign int_oe_next = primed_reg && (mism0 || mism1); // RULE11 RULE5

  always_ff @(posedge CLK or negedge rstn) begin
    if (!rstn) begin
      int_oe_reg <= 1'b0;
      int_o_reg <= INT_DRIVE_LEVEL;
    end else begin
      int_oe_reg <= int_oe_next; // RULE1 RULE2
      int_o_reg <= INT_DRIVE_LEVEL;
    end
  end

  assign INPUT_PORT0 = reg0;
  assign INPUT_PORT1 = reg1;
  assign INT_O = int_o_reg;
  assign INT_OE = int_oe_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rstn);

  a_change_raises: assert property ( // RULE1
    primed_reg && (mism0 || mism1) |=> INT_OE
  ) else $error("input mismatch did not pull the line");

  a_return_clears: assert property ( // RULE2
    primed_reg && !mism0 && !mism1 |=> !INT_OE
  ) else $error("line held with no mismatch");

  a_read_recaptures: assert property ( // RULE3
    primed_reg && READ_CAPTURE && sel_port0
      |=> reg0 == $past(sync0) && (!mism0 || sync0 != reg0)
  ) else $error("read of port 0 did not recapture the pins");

  a_output_masked: assert property ( // RULE4
    primed_reg && ((sync0 ^ reg0) & dir0) == 8'h00 && ((sync1 ^ reg1) & dir1) == 8'h00
      |=> !INT_OE
  ) else $error("output pin raised the interrupt");

  a_port_separate: assert property ( // RULE5
    primed_reg && !(READ_CAPTURE && sel_port0) |=> reg0 == $past(reg0)
  ) else $error("port 0 register changed without its own read");

  a_dir_switch: assert property ( // RULE6
    primed_reg && ((dir0 & ~$past(dir0) & (sync0 ^ reg0)) != 8'h00) |=> INT_OE
  ) else $error("direction switch with differing level gave no interrupt");

  a_input_on_one: assert property ( // RULE7
    mism1 == ((dir1 & (sync1 ^ reg1)) != 8'h00)
  ) else $error("port 1 cause disagrees with direction bits");

  a_ptr_select: assert property ( // RULE9
    primed_reg && READ_CAPTURE && sel_port1 |=> reg1 == $past(sync1) && reg0 == $past(reg0)
  ) else $error("pointer 1 did not select only port 1");

  a_sync_delay: assert property ( // RULE11
    primed_reg && $past(primed_reg, 2) |-> sync0 == $past(PIN_LEVEL[7:0], 2)
  ) else $error("pin synchroniser latency is not two cycles");

  a_line_low: assert property ( // RULE11
    INT_O == INT_DRIVE_LEVEL
  ) else $error("interrupt line drives a high level");

  a_read1_recaptures: assert property ( // RULE3
    primed_reg && READ_CAPTURE && sel_port1
      |=> reg1 == $past(sync1)
  ) else $error("read of port 1 did not recapture the pins");

  a_port1_separate: assert property ( // RULE5
    primed_reg && !(READ_CAPTURE && sel_port1)
      |=> reg1 == $past(reg1)
  ) else $error("port 1 register changed without its own read");

  a_port1_cause_kept: assert property ( // RULE5
    primed_reg && mism1 && READ_CAPTURE && sel_port0
      |=> INT_OE
  ) else $error("read of port 0 dropped the port 1 cause");

  a_dir1_switch: assert property ( // RULE6
    primed_reg && ((dir1 & ~$past(dir1) & (sync1 ^ reg1)) != 8'h00)
      |=> INT_OE
  ) else $error("port 1 direction switch with differing level gave no interrupt");

  a_port0_dirs: assert property ( // RULE7
    mism0 == ((dir0 & (sync0 ^ reg0)) != 8'h00)
  ) else $error("port 0 cause disagrees with direction bits");

  a_all_outputs: assert property ( // RULE4
    primed_reg && dir0 == 8'h00 && dir1 == 8'h00
      |=> !INT_OE
  ) else $error("all pins are outputs yet the line is pulled");

  a_capture_any_dir: assert property ( // RULE8
    primed_reg && READ_CAPTURE && sel_port0 && dir0 != 8'hff
      |=> reg0 == $past(sync0)
  ) else $error("port 0 capture depended on direction");

  a_prime_loads: assert property ( // RULE8
    $rose(primed_reg)
      |-> reg0 == $past(sync0) && reg1 == $past(sync1)
  ) else $error("input registers not loaded from the pins after reset");

  a_other_ptr: assert property ( // RULE9
    primed_reg && READ_CAPTURE && !sel_port0 && !sel_port1
      |=> reg0 == $past(reg0) && reg1 == $past(reg1)
  ) else $error("unknown pointer recaptured an input register");

  a_strobe_needed: assert property ( // RULE10
    primed_reg && !READ_CAPTURE
      |=> reg0 == $past(reg0) && reg1 == $past(reg1)
  ) else $error("input register changed without the capture strobe");

  a_sync1_delay: assert property ( // RULE11
    primed_reg && $past(primed_reg, 2)
      |-> sync1 == $past(PIN_LEVEL[15:8], 2)
  ) else $error("port 1 synchroniser latency is not two cycles");

  a_no_early_int: assert property ( // RULE11
    !primed_reg
      |=> !INT_OE
  ) else $error("line pulled before the input registers were loaded");

  a_idle_stable: assert property ( // RULE1
    primed_reg && $stable(sync0) && $stable(sync1) && $stable(reg0) && $stable(reg1)
      && $stable(DIR_CFG) && $past(primed_reg)
      |=> INT_OE == $past(INT_OE)
  ) else $error("line changed with no pin, direction or register change");
endmodule

//--- sim/ici_master.sv
// bus master side: pull-up on the interrupt line, issues the read capture strobe
module ici_master (
  input  wire logic       clk,
  input  wire logic       rd_go,
  input  wire logic [7:0] rd_ptr,
  input  wire logic       int_o,
  input  wire logic       int_oe,
  output logic      [7:0] read_ptr,
  output logic            read_capture,
  output logic            int_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // released line floats up through the pull-up
  assign int_n = int_oe ? int_o : 1'b1;
  initial read_ptr = 8'h00;
  initial read_capture = 1'b0;
  // idle pointer keeps toggling so a stale value never looks like a request
  always @(posedge clk) begin
    read_capture <= rd_go;
    read_ptr     <= rd_go ? rd_ptr : ~read_ptr;
  end
endmodule

//--- sim/ici_top_tb.sv
module ici_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ici_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] pins = 16'ha5c3;
  logic [15:0] dir = 16'hffff;
  logic        rd_go = 1'b0;
  logic [7:0]  rd_ptr = 8'h00;
  logic [7:0]  ptr, in0, in1, e0, e1;
  logic        cap, int_o, int_oe, int_n;
  logic [31:0] r = 32'h0423;
  int          n_fail = 0;
  int          checks = 0;
  always #2.5 clk = ~clk;
  ici_top u_ici_top (.CLK(clk), .RESETN(rstn), .PIN_LEVEL(pins), .DIR_CFG(dir),
    .READ_PTR(ptr), .READ_CAPTURE(cap), .INPUT_PORT0(in0), .INPUT_PORT1(in1),
    .INT_O(int_o), .INT_OE(int_oe));
  ici_master u_ici_master (.clk(clk), .rd_go(rd_go), .rd_ptr(rd_ptr), .int_o(int_o),
    .int_oe(int_oe), .read_ptr(ptr), .read_capture(cap), .int_n(int_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h got %h", name, exp, got);
    end
  endtask
  // settle pins, optionally read one port, then compare against the model
  task automatic step(input logic [15:0] p, input logic [15:0] d, input logic rd,
                      input logic [7:0] pt);
    @(posedge clk);
    pins <= p;
    dir  <= d;
    repeat (4) @(posedge clk);
    rd_go  <= rd;
    rd_ptr <= pt;
    @(posedge clk);
    rd_go <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    if (rd && pt == PTR_INPUT0) e0 = p[7:0];
    if (rd && pt == PTR_INPUT1) e1 = p[15:8];
    chk("input_port0", e0, in0);
    chk("input_port1", e1, in1);
    chk("int_n", {7'h00, ~|((p ^ {e1, e0}) & d)}, {7'h00, int_n});
  endtask
  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    e0 = 8'hc3;
    e1 = 8'ha5;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    step(16'ha5c2, 16'hffff, 1'b0, 8'h00);
    step(16'ha5c3, 16'hffff, 1'b0, 8'h00);
    step(16'ha4c3, 16'hffff, 1'b1, 8'h00);
    step(16'ha4c3, 16'hffff, 1'b1, 8'h01);
    step(16'ha4c1, 16'hfffd, 1'b0, 8'h00);
    step(16'ha4c1, 16'hffff, 1'b0, 8'h00);
    step(16'ha4c1, 16'hffff, 1'b1, 8'h02);
    step(16'ha4c1, 16'hffff, 1'b1, 8'h00);
    // random pins, directions and reads, pointer 0..3 so misses are exercised
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      step(r[15:0], {r[23:16], r[31:24]}, r[3], {6'h00, r[9:8]});
    end
    summarize();
  end
endmodule
